// [xfer_branch_regs.vh]
/*
 * Constants for the transfer, branch and immediate decoder: field
 * positions, selection codes and register map of the AXI4-Lite slave.
 * Assumes inclusion by bare name from the decoder module.
 */
`ifndef XFER_BRANCH_REGS_VH
`define XFER_BRANCH_REGS_VH

// ****************************************************************
// Instruction fields
// ****************************************************************
`define Q_FIELD_HI      12
`define Q_FIELD_LO      10
`define SOURCE_HI       9
`define SOURCE_LO       5
`define DSTF_HI         4
`define DSTF_LO         0
`define COND_HI         14
`define COND_LO         10
`define TGT_HI          12
`define TGT_LO          0
`define IMM_HI          31
`define IMM_LO          8

// ****************************************************************
// Source and destination codes
// ****************************************************************
`define SEL_NONE        5'h00
`define SEL_ROMPTR      5'h01
`define SEL_STATUS0     5'h02
`define SEL_STATUS1     5'h03
`define SEL_SHIFT       5'h04
`define SEL_STATUS      5'h05
`define SEL_LOOP        5'h06
`define SEL_STACK       5'h07
`define SEL_MUL         5'h08
`define SEL_MUL_LOW     5'h09
`define SEL_DROM        5'h0a
`define SEL_TEMP        5'h0b
`define SEL_EXTADDR     5'h0c
`define SEL_SERIAL      5'h0d
`define SEL_DATA        5'h0e
`define SEL_SLAVE       5'h0f
`define SEL_UNUSED      5'h1f
`define SEL_WR_BIT      4
`define SEL_HIGH_BASE   5'h18

// ****************************************************************
// Branch condition codes
// ****************************************************************
`define C_JUMP          5'h00
`define C_CALL          5'h01
`define C_RET           5'h02
`define C_ROMPTR_NZ     5'h03
`define C_FLAG_FIRST    5'h04
`define C_FLAG_LAST     5'h13
`define C_EXPOV0        5'h14
`define C_EXPOV1        5'h15
`define C_SI_NFULL      5'h16
`define C_SO_NEMPTY     5'h17
`define C_PORT0         5'h18
`define C_PORT1         5'h19
`define C_INDEX0_NZ     5'h1a
`define C_INDEX1_NZ     5'h1b
`define C_BASE0_NZ      5'h1c
`define C_BASE1_NZ      5'h1d
`define C_READY         5'h1e
`define C_MASTER_REQ    5'h1f

// ****************************************************************
// Instruction kinds (control register bits 1:0)
// ****************************************************************
`define KIND_NONE       2'h0
`define KIND_TRANSFER   2'h1
`define KIND_BRANCH     2'h2
`define KIND_LOAD_IMM   2'h3

// ****************************************************************
// Condition input bit positions in the flags register
// ****************************************************************
`define FLAG_ROMPTR_NZ  16
`define FLAG_EXPOV0     17
`define FLAG_EXPOV1     18
`define FLAG_SI_NFULL   19
`define FLAG_SO_NEMPTY  20
`define FLAG_PORT0      21
`define FLAG_PORT1      22
`define FLAG_INDEX0_NZ  23
`define FLAG_INDEX1_NZ  24
`define FLAG_BASE0_NZ   25
`define FLAG_BASE1_NZ   26
`define FLAG_READY      27
`define FLAG_MASTER_REQ 28

// ****************************************************************
// Register map (byte addresses)
// ****************************************************************
`define REG_INSTR       4'h0
`define REG_CTRL        4'h4
`define REG_FLAGS       4'h8
`define REG_DECODE      4'hc
`define AXI_OKAY        2'h0
`define AXI_DECERR      2'h3

`endif

// [dsp_transfer_branch_decoder.v]
/*
 * Decoder for operand select, bus transfer, branch and load-immediate
 * fields. Software loads the instruction word, kind and flag/status
 * inputs over AXI4-Lite; each decode is latched and presented on ports.
 * Assumes a single 20 MHz clock and synchronous active-low reset.
 */
// Decided for this implementation: the AXI4-Lite slave port and the address map.
// Contract
// (RULE1) Bits 12-10 pick working register 0..7 for second ALU input.
// (RULE2) Bits 9-5 pick bus source; 00000 drives nothing.
// (RULE3) Codes 00010 and 00011 select status words zero and one.
// (RULE4) 00001 ROM pointer, 00100 shift, 00101 status, 00110 loop, 00111 stack.
// (RULE5) Source 01000 multiplier, 01010 data ROM, 01101 serial input.
// (RULE6) Source 01001 gives only low 24 multiplier bits.
// (RULE7) 01110 data reg, 01111 host slave reg, 01100 address, 01011 temp.
// (RULE8) 10xxx working regs, 11000/11001 RAMs, 11010-11101 pointers, 11110 K.
// (RULE9) Bits 4-0 pick destination; 00000 none, 01101 serial output.
// (RULE10) 01000 loads L from bus, K from RAM block 0; 01001 the reverse.
// (RULE11) Destination 01010 writes temp exponent only; 01011 whole temp.
// (RULE12) Branch target comes from 13-bit next-address field.
// (RULE13) Target MSB chooses internal or external instruction memory.
// (RULE14) Bits 14-10 select branch kind: jump, call, return.
// (RULE15) 00011 branches when ROM pointer is nonzero.
// (RULE16) 00100-10011 test Z,C,S,V of sets 0,1; even set, odd clear.
// (RULE17) 10100/10101 branch on exponent overflow of set 0/1.
// (RULE18) 10110 serial input not full; 10111 serial output not empty.
// (RULE19) 11000/11001 branch on input port 0/1.
// (RULE20) 11010/11011 index nonzero; 11100/11101 base pointer nonzero.
// (RULE21) 11110 branch on ready; 11111 on master request.
// (RULE22) Transfer inside a branch always executes.
// (RULE23) Load immediate writes 24-bit field to destination register.
// (RULE24) Code 11111 selects no register: no drive, no write.
`timescale 1ns/1ps
`include "xfer_branch_regs.vh"

module dsp_transfer_branch_decoder #(
    parameter TGT_WIDTH = 13,
    parameter IMM_WIDTH = 24
) (
    input  wire                 aclk,           // System clock
    input  wire                 aresetn,        // Synchronous reset, low
    input  wire [3:0]           s_axi_awaddr,   // Write address
    input  wire                 s_axi_awvalid,  // Write address valid
    output reg                  s_axi_awready,  // Write address ready
    input  wire [31:0]          s_axi_wdata,    // Write data
    input  wire [3:0]           s_axi_wstrb,    // Write strobes
    input  wire                 s_axi_wvalid,   // Write data valid
    output reg                  s_axi_wready,   // Write data ready
    output reg  [1:0]           s_axi_bresp,    // Write response
    output reg                  s_axi_bvalid,   // Write response valid
    input  wire                 s_axi_bready,   // Write response ready
    input  wire [3:0]           s_axi_araddr,   // Read address
    input  wire                 s_axi_arvalid,  // Read address valid
    output reg                  s_axi_arready,  // Read address ready
    output reg  [31:0]          s_axi_rdata,    // Read data
    output reg  [1:0]           s_axi_rresp,    // Read response
    output reg                  s_axi_rvalid,   // Read valid
    input  wire                 s_axi_rready,   // Read ready
    output reg  [2:0]           q_select,       // Working reg to second ALU input
    output reg  [31:0]          source_onehot,  // Bus source one-hot, bit = code
    output reg                  bus_drive,      // Some source drives the bus
    output reg                  mul_low_only,   // Source is low 24 multiplier bits
    output reg  [31:0]          dest_onehot,    // Destination one-hot, bit = code
    output reg                  reg_write,      // Some destination is written
    output reg                  k_from_ram_zero,// K loaded from RAM block 0
    output reg                  l_from_ram_one, // L loaded from RAM block 1
    output reg                  temp_exp_only,  // Only temp exponent is written
    output reg                  imm_to_bus,     // Immediate drives the bus
    output reg  [IMM_WIDTH-1:0] immediate,      // Immediate value
    output reg                  branch_taken,   // Branch condition met
    output reg  [TGT_WIDTH-1:0] branch_target,  // Branch target address
    output reg                  target_external,// Target in external memory
    output reg                  branch_call,    // Branch is a subroutine call
    output reg                  branch_return,  // Branch is a return
    output reg                  decode_valid    // One-cycle pulse: new decode
);

// ****************************************************************
// Register file
// ****************************************************************
    reg  [31:0] instr_word;
    reg  [1:0]  instr_kind;
    reg  [31:0] cond_inputs;
    reg         aw_held;
    reg  [3:0]  aw_addr;
    reg         w_held;
    reg  [31:0] w_data;
    reg  [3:0]  w_strb;
    reg         decode_go;
    reg  [4:0]  source_code;
    reg  [4:0]  dest_onehot_code;

    wire        do_write = aw_held && w_held && !s_axi_bvalid;

    function [31:0] merge;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0]  strb;
        integer      i;
        begin
            for (i = 0; i < 4; i = i + 1) begin
                merge[i*8 +: 8] = strb[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
            end
        end
    endfunction

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `AXI_OKAY;
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 4'h0;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            instr_word    <= 32'h0000_0000;
            instr_kind    <= `KIND_NONE;
            cond_inputs   <= 32'h0000_0000;
            decode_go     <= 1'b0;
        end else begin
            decode_go     <= 1'b0;
            s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `AXI_OKAY;
                case (aw_addr)
                    `REG_INSTR: instr_word <= merge(instr_word, w_data, w_strb);
                    `REG_CTRL: begin
                        if (w_strb[0]) begin
                            instr_kind <= w_data[1:0];
                            decode_go  <= 1'b1;
                        end
                    end
                    `REG_FLAGS: cond_inputs <= merge(cond_inputs, w_data, w_strb);
                    `REG_DECODE: s_axi_bresp <= `AXI_OKAY;
                    default: s_axi_bresp <= `AXI_DECERR;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `AXI_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `AXI_OKAY;
                case (s_axi_araddr)
                    `REG_INSTR:  s_axi_rdata <= instr_word;
                    `REG_CTRL:   s_axi_rdata <= {30'h0000_0000, instr_kind};
                    `REG_FLAGS:  s_axi_rdata <= cond_inputs;
                    `REG_DECODE: s_axi_rdata <= {16'h0000, reg_write, bus_drive,
                                     branch_return, branch_call, target_external,
                                     branch_taken, dest_onehot_code, source_code};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= `AXI_DECERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

// ****************************************************************
// Field decode
// ****************************************************************
    // Condition inputs word: bits 0..7 hold the eight flags tested by codes
    // 00100-10011 in order (Z0,Z1,C0,C1,S0,S1,V0,V1 each set-level), then others.
    wire [4:0] src_code  = instr_word[`SOURCE_HI:`SOURCE_LO];
    wire [4:0] dst_code  = instr_word[`DSTF_HI:`DSTF_LO];
    wire [4:0] cond_code = instr_word[`COND_HI:`COND_LO];
    wire       is_branch = (instr_kind == `KIND_BRANCH);
    wire       is_ldi    = (instr_kind == `KIND_LOAD_IMM);
    wire       is_xfer   = (instr_kind == `KIND_TRANSFER) || is_branch; // RULE22
    reg        cond_met;
    reg  [4:0] flag_off;

    always @* begin
        flag_off = cond_code - `C_FLAG_FIRST;
        cond_met = 1'b0;
        if (cond_code >= `C_FLAG_FIRST && cond_code <= `C_FLAG_LAST) begin
            // Pairs: even code taken when set, odd when clear
            cond_met = cond_inputs[flag_off[4:1]] ^ flag_off[0]; // RULE16
        end else begin
            case (cond_code)
                `C_JUMP, `C_CALL, `C_RET: cond_met = 1'b1; // RULE14
                `C_ROMPTR_NZ: cond_met = cond_inputs[`FLAG_ROMPTR_NZ];  // RULE15
                `C_EXPOV0:    cond_met = cond_inputs[`FLAG_EXPOV0];     // RULE17
                `C_EXPOV1:    cond_met = cond_inputs[`FLAG_EXPOV1];     // RULE17
                `C_SI_NFULL:  cond_met = cond_inputs[`FLAG_SI_NFULL];   // RULE18
                `C_SO_NEMPTY: cond_met = cond_inputs[`FLAG_SO_NEMPTY];  // RULE18
                `C_PORT0:     cond_met = cond_inputs[`FLAG_PORT0];      // RULE19
                `C_PORT1:     cond_met = cond_inputs[`FLAG_PORT1];      // RULE19
                `C_INDEX0_NZ: cond_met = cond_inputs[`FLAG_INDEX0_NZ];  // RULE20
                `C_INDEX1_NZ: cond_met = cond_inputs[`FLAG_INDEX1_NZ];  // RULE20
                `C_BASE0_NZ:  cond_met = cond_inputs[`FLAG_BASE0_NZ];   // RULE20
                `C_BASE1_NZ:  cond_met = cond_inputs[`FLAG_BASE1_NZ];   // RULE20
                `C_READY:     cond_met = cond_inputs[`FLAG_READY];      // RULE21
                `C_MASTER_REQ: cond_met = cond_inputs[`FLAG_MASTER_REQ]; // RULE21
                default:      cond_met = 1'b0;
            endcase
        end
    end

    // Code 11111 is unassigned on both sides and must not select anything
    always @* begin
        source_code = (is_xfer && src_code != `SEL_UNUSED) ? src_code : `SEL_NONE; // RULE24
        dest_onehot_code = ((is_xfer || is_ldi) && dst_code != `SEL_UNUSED) ?
                           dst_code : `SEL_NONE; // RULE24
    end

// ****************************************************************
// Decode outputs, latched on each control write with byte 0 strobed
// ****************************************************************
    always @(posedge aclk) begin
        if (!aresetn) begin
            q_select        <= 3'h0;
            source_onehot   <= 32'h0000_0000;
            bus_drive       <= 1'b0;
            mul_low_only    <= 1'b0;
            dest_onehot     <= 32'h0000_0000;
            reg_write       <= 1'b0;
            k_from_ram_zero <= 1'b0;
            l_from_ram_one  <= 1'b0;
            temp_exp_only   <= 1'b0;
            imm_to_bus      <= 1'b0;
            immediate       <= {IMM_WIDTH{1'b0}};
            branch_taken    <= 1'b0;
            branch_target   <= {TGT_WIDTH{1'b0}};
            target_external <= 1'b0;
            branch_call     <= 1'b0;
            branch_return   <= 1'b0;
            decode_valid    <= 1'b0;
        end else begin
            decode_valid <= decode_go;
            if (decode_go) begin
                q_select      <= instr_word[`Q_FIELD_HI:`Q_FIELD_LO]; // RULE1
                // One-hot bit index equals the code, covering every
                // register from the ROM pointer up to K
                source_onehot <= (source_code == `SEL_NONE) ? 32'h0000_0000 :
                                 (32'h0000_0001 << source_code); // RULE2 RULE3 RULE4 RULE5 RULE7 RULE8
                bus_drive     <= (source_code != `SEL_NONE) || is_ldi; // RULE2
                mul_low_only  <= (source_code == `SEL_MUL_LOW); // RULE6
                dest_onehot   <= (dest_onehot_code == `SEL_NONE) ? 32'h0000_0000 :
                                 (32'h0000_0001 << dest_onehot_code); // RULE9 RULE3 RULE4 RULE7 RULE8
                reg_write     <= (dest_onehot_code != `SEL_NONE); // RULE9
                k_from_ram_zero <= (dest_onehot_code == `SEL_MUL); // RULE10
                l_from_ram_one  <= (dest_onehot_code == `SEL_MUL_LOW); // RULE10
                temp_exp_only <= (dest_onehot_code == `SEL_DROM); // RULE11
                imm_to_bus    <= is_ldi; // RULE23
                immediate     <= is_ldi ? instr_word[`IMM_HI:`IMM_LO] : {IMM_WIDTH{1'b0}}; // RULE23
                branch_taken  <= is_branch && cond_met;
                branch_target <= instr_word[`TGT_HI:`TGT_LO]; // RULE12
                target_external <= instr_word[`TGT_HI]; // RULE13
                branch_call   <= is_branch && (cond_code == `C_CALL); // RULE14
                branch_return <= is_branch && (cond_code == `C_RET); // RULE14
            end
        end
    end

endmodule // dsp_transfer_branch_decoder

// [imm_program_rom.sv]
/*
 * Instruction memory model: a few load-immediate words.
 * Assumes the bench fetches one word at a time by index.
 */
`timescale 1ns/1ps
module imm_program_rom (
    input  wire [1:0]  addr, // Word index
    output reg  [31:0] word  // Fetched instruction word
);
    // Immediate sits in bits 31-8, destination code in bits 4-0
    always @* begin
        case (addr)
            2'h0:    word = 32'h3F80_000A;
            2'h1:    word = 32'h1234_560B;
            2'h2:    word = 32'hABCD_EF1F;
            default: word = 32'h0000_0110;
        endcase
    end
endmodule // imm_program_rom

// [dsp_transfer_branch_decoder_props.sv]
/*
 * Checker for the decoder's output relations.
 * Assumes one clock domain and the top module's ports only.
 */
`timescale 1ns/1ps
module xfer_branch_checker #(
    parameter TGT_WIDTH = 13,
    parameter IMM_WIDTH = 24
) (
    input wire                aclk,            // System clock
    input wire                aresetn,         // Reset, low
    input wire [31:0]         source_onehot,   // Source select
    input wire                bus_drive,       // Bus driven
    input wire                mul_low_only,    // Low multiplier part
    input wire [31:0]         dest_onehot,     // Destination select
    input wire                reg_write,       // Register written
    input wire                k_from_ram_zero, // Dual load zero
    input wire                l_from_ram_one,  // Dual load one
    input wire                temp_exp_only,   // Exponent only
    input wire                imm_to_bus,      // Immediate on bus
    input wire                branch_taken,    // Branch taken
    input wire [TGT_WIDTH-1:0] branch_target,  // Target
    input wire                target_external, // External memory
    input wire                branch_call,     // Call
    input wire                branch_return,   // Return
    input wire                decode_valid     // New decode pulse
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_valid_one_cycle: assert property (decode_valid |=> !decode_valid)
        else $error("decode pulse longer than one cycle");
    // Outputs may only move together with a new decode
    a_hold_between: assert property (!decode_valid |-> $stable(source_onehot)
        && $stable(dest_onehot) && $stable(branch_taken))
        else $error("decode outputs changed without a decode");
    a_src_select: assert property ($onehot0(source_onehot)
        && !source_onehot[0] && !source_onehot[31])
        else $error("bad source select");
    a_mul_low: assert property (mul_low_only == source_onehot[9])
        else $error("low multiplier flag mismatch");
    a_dual_load: assert property ({temp_exp_only, l_from_ram_one, k_from_ram_zero}
        == dest_onehot[10:8])
        else $error("dual load or exponent flag mismatch");
    a_dest_select: assert property ($onehot0(dest_onehot) && !dest_onehot[0]
        && !dest_onehot[31] && reg_write == (dest_onehot != 32'h0000_0000))
        else $error("bad destination select");
    a_drive_flag: assert property (bus_drive ==
        (source_onehot != 32'h0000_0000 || imm_to_bus))
        else $error("bus drive flag mismatch");
    a_target_memory: assert property (target_external == branch_target[TGT_WIDTH-1])
        else $error("target memory select mismatch");
    a_uncond_taken: assert property ((branch_call || branch_return) |-> branch_taken)
        else $error("call or return not taken");

    c_taken: cover property (decode_valid && branch_taken);
    c_immediate: cover property (decode_valid && imm_to_bus);
    c_dual_load: cover property (decode_valid && k_from_ram_zero);
endmodule // xfer_branch_checker

bind dsp_transfer_branch_decoder xfer_branch_checker #(
    .TGT_WIDTH(TGT_WIDTH), .IMM_WIDTH(IMM_WIDTH)) chk_u (.*);

// [dsp_transfer_branch_decoder_tb_top.sv]
/*
 * Self-checking bench: drives decodes over AXI4-Lite, compares ports.
 * Assumes the decoder with its register map header.
 */
`timescale 1ns/1ps
`include "xfer_branch_regs.vh"
module dsp_transfer_branch_decoder_tb_top;
    logic aclk, aresetn, awvalid, wvalid, bvalid, bready, arvalid, rvalid, rready;
    logic awready, wready, arready, mul_low_only, bus_drive, reg_write, k0, l1, texp;
    logic imm_to_bus, taken, ext, call, ret, dv;
    logic [3:0]  awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata, src, dst;
    logic [1:0]  bresp, rresp, rom_addr;
    logic [2:0]  q_select;
    logic [23:0] immediate;
    logic [12:0] target;
    logic [31:0] rom_word, rd_val;
    int          num_errors, cmp_count, dv_cnt;

    dsp_transfer_branch_decoder dut_u (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .q_select(q_select),
        .source_onehot(src), .bus_drive(bus_drive), .mul_low_only(mul_low_only),
        .dest_onehot(dst), .reg_write(reg_write), .k_from_ram_zero(k0),
        .l_from_ram_one(l1), .temp_exp_only(texp), .imm_to_bus(imm_to_bus),
        .immediate(immediate), .branch_taken(taken), .branch_target(target),
        .target_external(ext), .branch_call(call), .branch_return(ret),
        .decode_valid(dv));
    imm_program_rom rom_u (.addr(rom_addr), .word(rom_word));

    // Each decode must give exactly one single-cycle pulse
    always @(posedge aclk) if (dv === 1'h1) dv_cnt <= dv_cnt + 1;

    initial begin
        aclk = 1'h0;
        forever #25 aclk = ~aclk;
    end

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Both channels offered together, each released when taken
    task automatic axw(input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= a; wdata <= d; awvalid <= 1'h1; wvalid <= 1'h1; bready <= 1'h1;
        do begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
        end while (bvalid !== 1'h1 && n < 100);
        bready <= 1'h0;
        if (n >= 100) num_errors++;
        chk("bresp", `AXI_OKAY, bresp);
    endtask

    task automatic axr(input logic [3:0] a, output logic [31:0] d);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a; arvalid <= 1'h1; rready <= 1'h1;
        do begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) arvalid <= 1'h0;
        end while (rvalid !== 1'h1 && n < 100);
        d = rdata;
        rready <= 1'h0;
        if (n >= 100) num_errors++;
        chk("rresp", `AXI_OKAY, rresp);
    endtask

    // Outputs land one edge after the response; they then hold
    task automatic dec(input logic [31:0] ins, input logic [1:0] kind, input logic [31:0] fl);
        axw(`REG_INSTR, ins);
        axw(`REG_FLAGS, fl);
        axw(`REG_CTRL, {30'h0000_0000, kind});
        @(posedge aclk);
        #1;
    endtask

    function automatic int fbit(input int c);
        if (c < 3) return 0;
        if (c == 3) return 16;
        if (c <= 19) return (c - 4) >> 1;
        return c - 3;
    endfunction

    initial begin
        logic [4:0] c, d;
        logic [31:0] w, fl;
        logic p, e;
        {awvalid, wvalid, bready, arvalid, rready, rom_addr} = '0;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hF;
        aresetn = 1'h0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        for (int i = 0; i < 32; i++) begin
            c = i[4:0];
            d = 5'h1F - c;
            dec({19'h0_0000, c[2:0], c, d}, `KIND_TRANSFER, 32'h0000_0000);
            chk("q_select", {29'h0000_0000, c[2:0]}, {29'h0000_0000, q_select});
            chk("source", (c == 0 || c == 31) ? 32'h0 : 32'h1 << c, src);
            chk("dest", (d == 0 || d == 31) ? 32'h0 : 32'h1 << d, dst);
            chk("mul_low", c == 5'h09, mul_low_only);
            chk("dual", {d == 5'h0A, d == 5'h09, d == 5'h08}, {texp, l1, k0});
            chk("drive", c != 0 && c != 31, bus_drive);
            chk("write", d != 0 && d != 31, reg_write);
        end
        for (int i = 0; i < 64; i++) begin
            c = i[5:1];
            p = i[0];
            fl = 32'h0000_0001 << fbit(c);
            if (!p) fl = ~fl;
            e = (c < 3) ? 1'h1 : (c >= 4 && c <= 19 && c[0]) ? !p : p;
            w = {17'h0_0000, c, 5'h0E, 5'h0D};
            dec(w, `KIND_BRANCH, fl);
            chk("taken", e, taken);
            chk("target", w[12:0], target);
            chk("external", w[12], ext);
            chk("call_ret", {c == 5'h01, c == 5'h02}, {call, ret});
            chk("xfer_src", 32'h0000_4000, src);
            chk("xfer_dst", 32'h0000_2000, dst);
        end
        for (int i = 0; i < 4; i++) begin
            rom_addr = i[1:0];
            #1;
            w = rom_word;
            dec(w, `KIND_LOAD_IMM, 32'h0000_0000);
            chk("immediate", {8'h00, w[31:8]}, {8'h00, immediate});
            chk("imm_bus", 2'h3, {imm_to_bus, bus_drive});
            chk("imm_src", 32'h0000_0000, src);
            chk("imm_dest", (w[4:0] == 5'h1F) ? 32'h0 : 32'h1 << w[4:0], dst);
            chk("imm_exp", w[4:0] == 5'h0A, texp);
        end
        dec(w, `KIND_NONE, 32'hFFFF_FFFF);
        chk("none_sel", 32'h0000_0000, dst | src);
        chk("none_flags", 32'h0000_0000, {taken, bus_drive, reg_write, imm_to_bus});
        axr(`REG_INSTR, rd_val);
        chk("instr_read", w, rd_val);
        chk("decode_pulses", 32'h0000_0065, dv_cnt);
        results();
    end

    initial begin
        repeat (20000) @(posedge aclk);
        num_errors++;
        results();
    end
endmodule // dsp_transfer_branch_decoder_tb_top
